// *** logic/spmh_pkg.sv ***
// Shared constants, register map and carrier types for the serial port block.
// Assumes a 10 MHz aclk and a single AXI4-Lite master in front of the block.
`default_nettype none
package spmh_pkg;
	// System clock rate.
	localparam int unsigned CLK_HZ  = 10_000_000;
	localparam int unsigned CLK_KHZ = CLK_HZ / 1000;
	// Modem turnaround delays in milliseconds.
	localparam int unsigned TA_A_MS = 10;
	localparam int unsigned TA_B_MS = 100;
	localparam int unsigned TA_C_MS = 500;
	// Selectable bit rates in bit/s; the highest is the reset choice.
	localparam int unsigned BAUD_TAB [7] = '{300, 600, 1200, 2400, 4800, 9600, 19200};
	localparam logic [2:0]  BAUD_RST     = 3'h6;
	localparam logic [2:0]  BAUD_MAX     = 3'h6;
	// Register byte offsets.
	localparam logic [7:0] OFS_MODE     = 8'h00;
	localparam logic [7:0] OFS_PCFG [2] = '{8'h04, 8'h08};
	localparam logic [7:0] OFS_STN      = 8'h0c;
	localparam logic [7:0] OFS_TX   [2] = '{8'h10, 8'h14};
	localparam logic [7:0] OFS_RX   [2] = '{8'h18, 8'h1c};
	localparam logic [7:0] OFS_STAT     = 8'h20;
	localparam logic [7:0] OFS_TMR  [2] = '{8'h24, 8'h28};
	// Values after reset and limits.
	localparam logic [3:0] MODE_RST = 4'h0;
	localparam logic [3:0] MODE_MAX = 4'h8;
	localparam logic [7:0] STN_RST  = 8'h01;
	localparam logic [1:0] AXI_OKAY   = 2'h0;
	localparam logic [1:0] AXI_SLVERR = 2'h2;
	// Protocol, parity and timeout codes.
	localparam logic [1:0] PROTO_ONE   = 2'h1;
	localparam logic [1:0] PROTO_TWO   = 2'h2;
	localparam logic [1:0] PROTO_THREE = 2'h3;
	localparam logic [1:0] PAR_ODD  = 2'h0;
	localparam logic [1:0] PAR_EVEN = 2'h1;
	// Port pairings, port 0 code in [3:2] and port 1 code in [1:0].
	localparam logic [3:0] PAIR_TAB [9] = '{4'h5, 4'h6, 4'h9, 4'ha, 4'hf, 4'hd, 4'h7, 4'he, 4'hb};
	// Third protocol timer sets per timeout code long, medium, short, none.
	localparam logic [15:0] T2_MS  [4] = '{16'h07d0, 16'h03e8, 16'h01f4, 16'h07d0};
	localparam logic [7:0]  T3P_S  [4] = '{8'h0a, 8'h0a, 8'h05, 8'h00};
	localparam logic [7:0]  T5_S   [4] = '{8'h00, 8'h05, 8'h02, 8'h00};
	// Handshake sequencer states.
	typedef enum {HS_IDLE, HS_KEY, HS_WCTS, HS_SEND} spmh_hs_t;
	// Per-port line settings as held in the port configuration register.
	typedef struct packed {
		logic [1:0] tmo;
		logic       stop2;
		logic [1:0] par;
		logic [1:0] ta;
		logic       hwfc;
		logic [2:0] baud;
		logic       rs485;
	} spmh_pcfg_t;
	localparam spmh_pcfg_t PCFG_RST = '{2'h0, 1'b0, PAR_ODD, 2'h0, 1'b0, BAUD_RST, 1'b0};
	// Clock cycles per bit for a rate index.
	function automatic logic [15:0] spmh_div(input logic [2:0] idx);
		logic [2:0] i;
		i = (idx > BAUD_MAX) ? BAUD_MAX : idx;
		return 16'(CLK_HZ / BAUD_TAB[i]);
	endfunction : spmh_div
	// Turnaround delay in milliseconds for a delay code.
	function automatic logic [15:0] spmh_ta_ms(input logic [1:0] ta);
		case (ta)
			2'h1: return 16'(TA_A_MS);
			2'h2: return 16'(TA_B_MS);
			2'h3: return 16'(TA_C_MS);
			default: return 16'h0000;
		endcase
	endfunction : spmh_ta_ms
endpackage : spmh_pkg
`default_nettype wire

// *** logic/spmh_rx.sv ***
// Receive shifter sampling each bit at its middle.
// Assumes rxd is already synchronised to aclk.
`default_nettype none
module spmh_rx
	import spmh_pkg::*;
(
	input  wire logic        aclk,
	input  wire logic        aresetn,
	input  wire logic        en,
	input  wire logic        rxd,
	input  wire logic [1:0]  par,
	input  wire logic [15:0] div,
	output logic             done,
	output logic [7:0]       data,
	output logic             perr,
	output logic             ferr
);
	logic        act_r;
	logic [15:0] cnt_r;
	logic [3:0]  idx_r;
	logic [8:0]  sh_r;
	logic        npar;
	logic [7:0]  dbyte;
	logic [3:0]  last;

	assign npar  = (par != PAR_ODD) && (par != PAR_EVEN);
	assign dbyte = npar ? sh_r[8:1] : sh_r[7:0];
	assign last  = npar ? 4'h8 : 4'h9;

	// A low line while idle starts a frame; a high middle of start is a glitch.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			act_r <= 1'b0;
			cnt_r <= 16'h0000;
			idx_r <= 4'h0;
			sh_r  <= 9'h000;
			done  <= 1'b0;
			data  <= 8'h00;
			perr  <= 1'b0;
			ferr  <= 1'b0;
		end else begin
			done <= 1'b0;
			if (!act_r) begin
				if (en && !rxd) begin
					act_r <= 1'b1;
					cnt_r <= {1'b0, div[15:1]};
					idx_r <= 4'h0;
				end
			end else if (cnt_r != 16'h0000) begin
				cnt_r <= cnt_r - 16'h0001;
			end else begin
				cnt_r <= div - 16'h0001;
				if (idx_r == 4'h0) begin
					act_r <= !rxd;
					idx_r <= 4'h1;
				end else if (idx_r <= last) begin
					sh_r  <= {rxd, sh_r[8:1]};
					idx_r <= idx_r + 4'h1;
				end else begin
					act_r <= 1'b0;
					done  <= 1'b1;
					data  <= dbyte;
					perr  <= !npar && (sh_r[8] != ((par == PAR_EVEN) ? ^dbyte : ~^dbyte));
					ferr  <= !rxd;
				end
			end
		end
	end
endmodule : spmh_rx
`default_nettype wire

// *** logic/spmh_top.sv ***
// Two serial ports with protocol selection and modem handshake, AXI4-Lite registers.
// Assumes a 10 MHz aclk, one bus master, and line pins from outside the clock domain.
// Summary of operation
// - Each port runs one protocol; nine pairings accepted, third implies extended.
// - After reset both ports run the first protocol.
// - New station identifier takes effect only after restart; reset returns it to 01.
// - Each port picks RS-485 or RS-232; single-connector port 0 is RS-232.
// - Seven bit rates from 300 to 19200 bit/s, 19200 after reset.
// - Flow control none or hardware; hardware refused on RS-485.
// - Without flow control only data lines carry data; RTS keys the modem.
// - Without flow control RTS covers delay and characters, drops right after.
// - Turnaround none, 10, 100 or 500 ms sets RTS lead time.
// - Hardware flow control raises RTS at every transmission start.
// - Hardware flow control holds characters until CTS returns.
// - Hardware flow control drops RTS once characters are sent.
// - Hardware flow control: turnaround only lengthens timers, not RTS.
// - DTR stays asserted at all times.
// - Third protocol timeout choice loads a fixed timer set.
`default_nettype none
module spmh_top
	import spmh_pkg::*;
#(
	parameter bit          SINGLE_CONN = 1'b0,
	parameter int unsigned TA_A_CYC    = TA_A_MS * CLK_KHZ,
	parameter int unsigned TA_B_CYC    = TA_B_MS * CLK_KHZ,
	parameter int unsigned TA_C_CYC    = TA_C_MS * CLK_KHZ
) (
	input  wire logic        aclk,
	input  wire logic        aresetn,
	input  wire logic [7:0]  s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [7:0]  s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	input  wire logic        restart_n,
	input  wire logic [1:0]  rxd,
	input  wire logic [1:0]  cts,
	input  wire logic [1:0]  dcd,
	output logic [1:0]       txd,
	output logic [1:0]       rts,
	output logic [1:0]       dtr,
	output logic [1:0]       if485,
	output logic [1:0]       proto0,
	output logic [1:0]       proto1,
	output logic [7:0]       station_id
);
	logic             aw_have_r;
	logic             aw_have_nxt;
	logic [7:0]       aw_q_r;
	logic             w_have_r;
	logic             w_have_nxt;
	logic [31:0]      w_q_r;
	logic [3:0]       w_strb_r;
	logic             wr_fire;
	logic             wr_hit;
	logic             ar_fire;
	logic             rvalid_nxt;
	logic [31:0]      rd_val;
	logic             rd_err;
	logic [3:0]       mode_r;
	spmh_pcfg_t       pcfg_r [2];
	logic [7:0]       stn_stage_r;
	logic             rst_m_r;
	logic             rst_s_r;
	logic             rst_d_r;
	logic [1:0]       cts_m_r;
	logic [1:0]       cts_s_r;
	logic [1:0]       dcd_m_r;
	logic [1:0]       dcd_s_r;
	logic [1:0]       rxd_m_r;
	logic [1:0]       rxd_s_r;
	logic [1:0]       pend_r;
	logic [7:0]       txb_r [2];
	spmh_hs_t         hs_r [2];
	logic [22:0]      ta_cnt_r [2];
	logic [1:0]       rts_r;
	logic [1:0]       launch;
	logic [1:0]       flow_eff;
	logic [1:0]       tx_busy;
	logic [1:0]       rx_done;
	logic [7:0]       rx_data [2];
	logic [1:0]       rx_perr;
	logic [1:0]       rx_ferr;
	logic [1:0]       rxv_r;
	logic [1:0]       ovr_r;
	logic [1:0]       perr_r;
	logic [1:0]       ferr_r;
	logic [7:0]       rxb_r [2];
	logic [1:0]       rx_clr;
	logic [31:0]      tmr_r [2];
	logic [7:0]       stat_b [2];
	logic [3:0]       pair;

	// Byte-lane mask from the write strobes.
	function automatic logic [31:0] lane_mask(input logic [3:0] s);
		return {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
	endfunction : lane_mask

	// Merges a port configuration write, cleaning choices the port cannot take.
	function automatic spmh_pcfg_t pcfg_merge(input spmh_pcfg_t old, input logic [31:0] wd,
		input logic [3:0] s, input bit first);
		logic [31:0] m;
		logic [31:0] v;
		spmh_pcfg_t  c;
		m = lane_mask(s);
		v = ({20'h00000, old} & ~m) | (wd & m);
		c = spmh_pcfg_t'(v[11:0]);
		if (first && SINGLE_CONN)
			c.rs485 = 1'b0;
		if (c.rs485)
			c.hwfc = 1'b0;
		if (c.baud > BAUD_MAX)
			c = old;
		return c;
	endfunction : pcfg_merge

	// Turnaround lead time in clock cycles.
	function automatic logic [22:0] ta_cycles(input logic [1:0] ta);
		case (ta)
			2'h1: return 23'(TA_A_CYC);
			2'h2: return 23'(TA_B_CYC);
			2'h3: return 23'(TA_C_CYC);
			default: return 23'h000000;
		endcase
	endfunction : ta_cycles

	// Write address and data are each held until both are present.
	assign wr_fire     = aw_have_r && w_have_r && !s_axi_bvalid;
	assign aw_have_nxt = (s_axi_awvalid && s_axi_awready) || (aw_have_r && !wr_fire);
	assign w_have_nxt  = (s_axi_wvalid && s_axi_wready) || (w_have_r && !wr_fire);
	assign ar_fire     = s_axi_arvalid && s_axi_arready;
	assign rvalid_nxt  = ar_fire || (s_axi_rvalid && !s_axi_rready);

	// Offsets that answer a write with OKAY.
	assign wr_hit = (aw_q_r == OFS_MODE) || (aw_q_r == OFS_STN) || (aw_q_r == OFS_STAT)
		|| (aw_q_r == OFS_PCFG[0]) || (aw_q_r == OFS_PCFG[1]) || (aw_q_r == OFS_TX[0])
		|| (aw_q_r == OFS_TX[1]) || (aw_q_r == OFS_RX[0]) || (aw_q_r == OFS_RX[1])
		|| (aw_q_r == OFS_TMR[0]) || (aw_q_r == OFS_TMR[1]);

	// Write channels and response.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_have_r     <= 1'b0;
			w_have_r      <= 1'b0;
			aw_q_r        <= 8'h00;
			w_q_r         <= 32'h00000000;
			w_strb_r      <= 4'h0;
			s_axi_awready <= 1'b0;
			s_axi_wready  <= 1'b0;
			s_axi_bvalid  <= 1'b0;
			s_axi_bresp   <= AXI_OKAY;
		end else begin
			aw_have_r     <= aw_have_nxt;
			w_have_r      <= w_have_nxt;
			s_axi_awready <= !aw_have_nxt;
			s_axi_wready  <= !w_have_nxt;
			if (s_axi_awvalid && s_axi_awready)
				aw_q_r <= s_axi_awaddr;
			if (s_axi_wvalid && s_axi_wready) begin
				w_q_r    <= s_axi_wdata;
				w_strb_r <= s_axi_wstrb;
			end
			if (wr_fire) begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= wr_hit ? AXI_OKAY : AXI_SLVERR;
			end else if (s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	// Read data selection; unmapped offsets answer SLVERR with zero.
	always_comb begin
		rd_val = 32'h00000000;
		rd_err = 1'b0;
		if (s_axi_araddr == OFS_MODE)
			rd_val = {28'h0000000, mode_r};
		else if (s_axi_araddr == OFS_STN)
			rd_val = {16'h0000, station_id, stn_stage_r};
		else if (s_axi_araddr == OFS_STAT)
			rd_val = {16'h0000, stat_b[1], stat_b[0]};
		else if (s_axi_araddr == OFS_PCFG[0])
			rd_val = {20'h00000, pcfg_r[0]};
		else if (s_axi_araddr == OFS_PCFG[1])
			rd_val = {20'h00000, pcfg_r[1]};
		else if (s_axi_araddr == OFS_TX[0])
			rd_val = {23'h000000, pend_r[0], txb_r[0]};
		else if (s_axi_araddr == OFS_TX[1])
			rd_val = {23'h000000, pend_r[1], txb_r[1]};
		else if (s_axi_araddr == OFS_RX[0])
			rd_val = {20'h00000, ferr_r[0], perr_r[0], ovr_r[0], rxv_r[0], rxb_r[0]};
		else if (s_axi_araddr == OFS_RX[1])
			rd_val = {20'h00000, ferr_r[1], perr_r[1], ovr_r[1], rxv_r[1], rxb_r[1]};
		else if (s_axi_araddr == OFS_TMR[0])
			rd_val = tmr_r[0];
		else if (s_axi_araddr == OFS_TMR[1])
			rd_val = tmr_r[1];
		else
			rd_err = 1'b1;
	end

	// Read channel; reading a receive register also clears its valid and overrun flags.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= 32'h00000000;
			s_axi_rresp   <= AXI_OKAY;
		end else begin
			s_axi_rvalid  <= rvalid_nxt;
			s_axi_arready <= !rvalid_nxt;
			if (ar_fire) begin
				s_axi_rdata <= rd_val;
				s_axi_rresp <= rd_err ? AXI_SLVERR : AXI_OKAY;
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn)
			mode_r <= MODE_RST;
		else if (wr_fire && aw_q_r == OFS_MODE && w_strb_r[0] && w_q_r[3:0] <= MODE_MAX)
			mode_r <= w_q_r[3:0];
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			pcfg_r      <= '{PCFG_RST, PCFG_RST};
			stn_stage_r <= STN_RST;
		end else if (wr_fire) begin
			if (aw_q_r == OFS_PCFG[0])
				pcfg_r[0] <= pcfg_merge(pcfg_r[0], w_q_r, w_strb_r, 1'b1);
			else if (aw_q_r == OFS_PCFG[1])
				pcfg_r[1] <= pcfg_merge(pcfg_r[1], w_q_r, w_strb_r, 1'b0);
			else if (aw_q_r == OFS_STN && w_strb_r[0])
				stn_stage_r <= w_q_r[7:0];
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			cts_m_r <= 2'h0;
			cts_s_r <= 2'h0;
			dcd_m_r <= 2'h0;
			dcd_s_r <= 2'h0;
			rxd_m_r <= 2'h3;
			rxd_s_r <= 2'h3;
			rst_m_r <= 1'b1;
			rst_s_r <= 1'b1;
			rst_d_r <= 1'b1;
		end else begin
			cts_m_r <= cts;
			cts_s_r <= cts_m_r;
			dcd_m_r <= dcd;
			dcd_s_r <= dcd_m_r;
			rxd_m_r <= rxd;
			rxd_s_r <= rxd_m_r;
			rst_m_r <= restart_n;
			rst_s_r <= rst_m_r;
			rst_d_r <= rst_s_r;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn)
			station_id <= STN_RST;
		else if (rst_d_r && !rst_s_r)
			station_id <= stn_stage_r;
	end

	// Decoded protocol per port, third code also carries the extended variant.
	assign pair = PAIR_TAB[mode_r];
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			proto0 <= PROTO_ONE;
			proto1 <= PROTO_ONE;
		end else begin
			proto0 <= pair[3:2];
			proto1 <= pair[1:0];
		end
	end

	// Per-port flow control in force, launch condition and status byte.
	always_comb begin
		for (int p = 0; p < 2; p++) begin
			flow_eff[p] = pcfg_r[p].hwfc && !pcfg_r[p].rs485;
			launch[p]   = (hs_r[p] == HS_SEND) && pend_r[p] && !tx_busy[p]
				&& (!flow_eff[p] || cts_s_r[p]);
			rx_clr[p]   = ar_fire && (s_axi_araddr == OFS_RX[p]);
			stat_b[p]   = {1'b0, flow_eff[p], rxv_r[p], dcd_s_r[p], cts_s_r[p], rts_r[p],
				tx_busy[p], pend_r[p]};
		end
	end

	// One-byte transmit holding register per port; writes while full are dropped.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			pend_r <= 2'h0;
			txb_r  <= '{8'h00, 8'h00};
		end else begin
			for (int p = 0; p < 2; p++) begin
				if (launch[p]) begin
					pend_r[p] <= 1'b0;
				end else if (wr_fire && aw_q_r == OFS_TX[p] && w_strb_r[0] && !pend_r[p]) begin
					pend_r[p] <= 1'b1;
					txb_r[p]  <= w_q_r[7:0];
				end
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			hs_r     <= '{HS_IDLE, HS_IDLE};
			ta_cnt_r <= '{23'h000000, 23'h000000};
			rts_r    <= 2'h0;
		end else begin
			for (int p = 0; p < 2; p++) begin
				case (hs_r[p])
					HS_IDLE: begin
						if (pend_r[p]) begin
							rts_r[p] <= 1'b1;
							if (flow_eff[p]) begin
								hs_r[p] <= HS_WCTS;
							end else if (pcfg_r[p].ta == 2'h0) begin
								hs_r[p] <= HS_SEND;
							end else begin
								hs_r[p]     <= HS_KEY;
								ta_cnt_r[p] <= ta_cycles(pcfg_r[p].ta) - 23'h000001;
							end
						end
					end
					HS_KEY: begin
						if (ta_cnt_r[p] == 23'h000000)
							hs_r[p] <= HS_SEND;
						else
							ta_cnt_r[p] <= ta_cnt_r[p] - 23'h000001;
					end
					HS_WCTS: begin
						if (cts_s_r[p])
							hs_r[p] <= HS_SEND;
					end
					HS_SEND: begin
						if (!pend_r[p] && !tx_busy[p] && !launch[p]) begin
							rts_r[p] <= 1'b0;
							hs_r[p]  <= HS_IDLE;
						end
					end
					default: hs_r[p] <= HS_IDLE;
				endcase
			end
		end
	end

	// Receive flags; a new character wins over a clearing read in the same cycle.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rxv_r  <= 2'h0;
			ovr_r  <= 2'h0;
			perr_r <= 2'h0;
			ferr_r <= 2'h0;
			rxb_r  <= '{8'h00, 8'h00};
		end else begin
			for (int p = 0; p < 2; p++) begin
				if (rx_done[p]) begin
					rxv_r[p]  <= 1'b1;
					ovr_r[p]  <= rxv_r[p] && !rx_clr[p];
					perr_r[p] <= rx_perr[p];
					ferr_r[p] <= rx_ferr[p];
					rxb_r[p]  <= rx_data[p];
				end else if (rx_clr[p]) begin
					rxv_r[p] <= 1'b0;
					ovr_r[p] <= 1'b0;
				end
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			tmr_r <= '{32'h00000000, 32'h00000000};
		end else begin
			for (int p = 0; p < 2; p++) begin
				if ((p == 0 ? pair[3:2] : pair[1:0]) != PROTO_THREE)
					tmr_r[p] <= 32'h00000000;
				else if (flow_eff[p])
					tmr_r[p] <= {T5_S[pcfg_r[p].tmo], T3P_S[pcfg_r[p].tmo],
						T2_MS[pcfg_r[p].tmo] + spmh_ta_ms(pcfg_r[p].ta)};
				else
					tmr_r[p] <= {T5_S[pcfg_r[p].tmo], T3P_S[pcfg_r[p].tmo],
						T2_MS[pcfg_r[p].tmo]};
			end
		end
	end

	always_ff @(posedge aclk) begin
		dtr <= 2'h3;
	end

	assign rts   = rts_r;
	assign if485 = {pcfg_r[1].rs485, pcfg_r[0].rs485};

	// Line shifters for each port.
	for (genvar g = 0; g < 2; g++) begin : g_port
		spmh_tx u_tx (
			.aclk    (aclk),
			.aresetn (aresetn),
			.start   (launch[g]),
			.data    (txb_r[g]),
			.par     (pcfg_r[g].par),
			.stop2   (pcfg_r[g].stop2),
			.div     (spmh_div(pcfg_r[g].baud)),
			.busy    (tx_busy[g]),
			.txd     (txd[g])
		);
		spmh_rx u_rx (
			.aclk    (aclk),
			.aresetn (aresetn),
			.en      (!flow_eff[g] || dcd_s_r[g]),
			.rxd     (rxd_s_r[g]),
			.par     (pcfg_r[g].par),
			.div     (spmh_div(pcfg_r[g].baud)),
			.done    (rx_done[g]),
			.data    (rx_data[g]),
			.perr    (rx_perr[g]),
			.ferr    (rx_ferr[g])
		);
	end
endmodule : spmh_top
`default_nettype wire

// *** logic/spmh_tx.sv ***
// Transmit shifter: start bit, eight data bits, optional parity, one or two stops.
// Assumes start is only raised while busy is low and data is stable with it.
`default_nettype none
module spmh_tx
	import spmh_pkg::*;
(
	input  wire logic        aclk,
	input  wire logic        aresetn,
	input  wire logic        start,
	input  wire logic [7:0]  data,
	input  wire logic [1:0]  par,
	input  wire logic        stop2,
	input  wire logic [15:0] div,
	output logic             busy,
	output logic             txd
);
	logic [11:0] sh_r;
	logic [3:0]  left_r;
	logic [15:0] cnt_r;
	logic [15:0] div_r;
	logic        npar;
	logic        pbit;
	logic [11:0] frame;
	logic [3:0]  nbits;

	// Frame is built least significant bit first, stop bits padding the top.
	assign npar  = (par != PAR_ODD) && (par != PAR_EVEN);
	assign pbit  = (par == PAR_EVEN) ? ^data : ~^data;
	assign frame = npar ? {3'b111, data, 1'b0} : {2'b11, pbit, data, 1'b0};
	assign nbits = 4'ha + {3'h0, !npar} + {3'h0, stop2};

	// Busy stays high until the last stop bit has had its full bit time.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			busy   <= 1'b0;
			txd    <= 1'b1;
			sh_r   <= 12'hfff;
			left_r <= 4'h0;
			cnt_r  <= 16'h0000;
			div_r  <= 16'h0000;
		end else if (!busy) begin
			if (start) begin
				busy   <= 1'b1;
				sh_r   <= frame;
				txd    <= frame[0];
				left_r <= nbits;
				div_r  <= div;
				cnt_r  <= div - 16'h0001;
			end
		end else if (cnt_r != 16'h0000) begin
			cnt_r <= cnt_r - 16'h0001;
		end else if (left_r == 4'h1) begin
			busy <= 1'b0;
			txd  <= 1'b1;
		end else begin
			sh_r   <= {1'b1, sh_r[11:1]};
			txd    <= sh_r[1];
			left_r <= left_r - 4'h1;
			cnt_r  <= div_r - 16'h0001;
		end
	end
endmodule : spmh_tx
`default_nettype wire

// *** tb/spmh_remote.sv ***
// Remote modem model: returns CTS some cycles after RTS, holds DCD up.
// Assumes RTS is sampled on aclk; receive lines echo the transmit lines.
`default_nettype none
module spmh_remote #(
	parameter int CTS_DLY = 50
) (
	input wire logic       aclk,
	input wire logic [1:0] rts,
	input wire logic [1:0] txd,
	output logic [1:0]     cts,
	output logic [1:0]     dcd,
	output logic [1:0]     rxd
);
	int cnt [2];
	assign dcd = 2'h3;
	// Each receive line echoes its transmit line, as a loopback plug would.
	assign rxd = txd;
	// Answers RTS late so that held-back characters show.
	always_ff @(posedge aclk) begin
		for (int p = 0; p < 2; p++) begin
			cnt[p] <= rts[p] ? cnt[p] + 1 : 0;
			cts[p] <= rts[p] && cnt[p] >= CTS_DLY;
		end
	end
endmodule : spmh_remote
`default_nettype wire

// *** tb/spmh_sva.sv ***
// Port-level checker for the serial port block.
// Assumes the top's port names; SINGLE_CONN is handed on by the bind.
`default_nettype none
module spmh_sva
	import spmh_pkg::*;
#(
	parameter bit SINGLE_CONN = 1'b0
) (
	input wire logic       aclk,
	input wire logic       aresetn,
	input wire logic       restart_n,
	input wire logic       s_axi_arready,
	input wire logic       s_axi_rvalid,
	input wire logic [1:0] txd,
	input wire logic [1:0] rts,
	input wire logic [1:0] dtr,
	input wire logic [1:0] if485,
	input wire logic [1:0] proto0,
	input wire logic [1:0] proto1,
	input wire logic [7:0] station_id
);
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	// Line, protocol and bus relations at the ports.
	property p_dtr; dtr == 2'h3; endproperty
	a_dtr: assert property (p_dtr) else $error("dtr dropped");
	property p_key; (~txd & ~rts) == 2'h0; endproperty
	a_key: assert property (p_key) else $error("data sent without rts");
	property p_tail; $fell(rts[0]) |-> $past(txd[0]) && $past(txd[0], 8); endproperty
	a_tail: assert property (p_tail) else $error("rts fell inside a frame");
	property p_lead; $rose(rts[0]) |-> $past(txd[0]) && txd[0]; endproperty
	a_lead: assert property (p_lead) else $error("char at rts rise");
	property p_stn;
		$changed(station_id) |-> !$past(restart_n, 2) || !$past(restart_n, 3) || !$past(restart_n, 4);
	endproperty
	a_stn: assert property (p_stn) else $error("id changed without restart");
	property p_proto; proto0 != 2'h0 && proto1 != 2'h0; endproperty
	a_proto: assert property (p_proto) else $error("no protocol");
	property p_one232; SINGLE_CONN |-> !if485[0]; endproperty
	a_one232: assert property (p_one232) else $error("port 0 on rs485");
	property p_arhold; s_axi_rvalid |-> !s_axi_arready; endproperty
	a_arhold: assert property (p_arhold) else $error("arready during rvalid");
	// Main scenarios reached.
	c_fall: cover property ($fell(rts[0]));
	c_stn: cover property ($changed(station_id));
	c_485: cover property (if485[1]);
endmodule : spmh_sva
bind spmh_top spmh_sva #(.SINGLE_CONN(SINGLE_CONN)) u_sva (
	.aclk          (aclk),
	.aresetn       (aresetn),
	.restart_n     (restart_n),
	.s_axi_arready (s_axi_arready),
	.s_axi_rvalid  (s_axi_rvalid),
	.txd           (txd),
	.rts           (rts),
	.dtr           (dtr),
	.if485         (if485),
	.proto0        (proto0),
	.proto1        (proto1),
	.station_id    (station_id)
);
`default_nettype wire

// *** tb/test_serial_port_modem_handshake.sv ***
// Testbench driving the register bus and watching the modem lines.
// Assumes short turnaround parameters and the remote model on the far side.
`default_nettype none
module test_serial_port_modem_handshake
	import spmh_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	localparam int BIT = 520;
	localparam int DLY = 50;
	localparam logic [31:0] TMR [4] = '{32'h000a07d0, 32'h050a03e8, 32'h020501f4, 32'h000007d0};
	logic        aclk = 1'b0, aresetn = 1'b0, restart_n = 1'b1;
	logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_arvalid = 1'b0;
	logic        s_axi_bready = 1'b1, s_axi_rready = 1'b1;
	logic [3:0]  s_axi_wstrb = 4'hf;
	logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00, station_id;
	logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rd_d;
	logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0]  s_axi_bresp, s_axi_rresp, rxd, cts, dcd, txd, rts, dtr, if485, proto0, proto1;
	int          err_count = 0, checks = 0;
	spmh_top #(.SINGLE_CONN(1'b1), .TA_A_CYC(20), .TA_B_CYC(40), .TA_C_CYC(80)) u_dut (.*);
	spmh_remote #(.CTS_DLY(DLY)) u_rem (.*);
	// Free-running system clock.
	initial begin
		forever #50 aclk = ~aclk;
	end
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
		checks++;
		if (s !== e) begin
			err_count++;
			$display("[FAIL] %s expected %h seen %h", nm, e, s);
		end
	endtask : chk
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		do begin
			@(posedge aclk);
			if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
		end while (s_axi_bvalid !== 1'b1);
		chk("bresp", AXI_OKAY, s_axi_bresp);
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [31:0] e, input string nm);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		do begin
			@(posedge aclk);
			if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
		end while (s_axi_rvalid !== 1'b1);
		rd_d = s_axi_rdata;
		chk(nm, e, rd_d);
	endtask : rd
	// Times the RTS lead, reads the byte and times the RTS tail.
	task automatic txf(input int lo, input int hi, input logic [7:0] b);
		int n;
		logic [7:0] g;
		n = 0;
		while (rts[0] !== 1'b1) @(posedge aclk);
		while (txd[0] !== 1'b0) begin
			@(posedge aclk);
			n++;
		end
		chk("lead", 1, 32'(n >= lo && n <= hi));
		repeat (BIT + BIT / 2) @(posedge aclk);
		for (int i = 0; i < 8; i++) begin
			g[i] = txd[0];
			repeat (BIT) @(posedge aclk);
		end
		chk("data", b, g);
		n = 0;
		while (rts[0] === 1'b1) begin
			@(posedge aclk);
			n++;
		end
		chk("tail", 1, 32'(n >= 3 * BIT / 2 && n <= 3 * BIT / 2 + 8));
	endtask : txf
	task automatic end_of_test();
		$display("checks %0d mismatches %0d", checks, err_count);
		if (err_count == 0 && checks > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask : end_of_test
	// Cuts a hang short.
	initial begin
		repeat (30000) @(posedge aclk);
		err_count++;
		end_of_test();
	end
	// Test sequence.
	initial begin
		repeat (8) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		rd(OFS_PCFG[0], 32'h00c, "pcfg0");
		chk("proto", 4'h5, {proto0, proto1});
		chk("dtr", 2'h3, dtr);
		$display("test reset done");
		for (int i = 0; i < 10; i++) begin
			wr(OFS_MODE, i);
			// Protocol outputs follow the mode register one clock later.
			@(posedge aclk);
			chk("pair", PAIR_TAB[i > 8 ? 8 : i], {proto0, proto1});
		end
		wr(OFS_MODE, 32'h4);
		for (int t = 0; t < 4; t++) begin
			wr(OFS_PCFG[0], 32'h00c | (t << 10));
			rd(OFS_TMR[0], TMR[t], "tmr");
		end
		$display("test modes done");
		wr(OFS_PCFG[1], 32'h01d);
		rd(OFS_PCFG[1], 32'h00d, "pcfg1");
		wr(OFS_PCFG[0], 32'h001);
		chk("if485", 2'h2, if485);
		rd(8'h3c, 32'h0, "unmapped");
		chk("rresp", AXI_SLVERR, s_axi_rresp);
		wr(OFS_MODE, 32'h0);
		wr(OFS_PCFG[0], 32'h02c);
		wr(OFS_TX[0], 32'h55);
		txf(18, 26, 8'h55);
		rd(OFS_RX[0], 32'h155, "rx0");
		wr(OFS_PCFG[0], 32'h07c);
		wr(OFS_TX[0], 32'ha3);
		txf(DLY, DLY + 10, 8'ha3);
		rd(OFS_RX[0], 32'h1a3, "rx0");
		$display("test line done");
		wr(OFS_STN, 32'h2a);
		chk("stn", STN_RST, station_id);
		restart_n <= 1'b0;
		repeat (4) @(posedge aclk);
		restart_n <= 1'b1;
		repeat (6) @(posedge aclk);
		chk("stn", 8'h2a, station_id);
		$display("test restart done");
		end_of_test();
	end
endmodule : test_serial_port_modem_handshake
`default_nettype wire
